// file: hdl/hbd_pkg.sv
// constants and carrier types for the multiplexed host bus decoder
package hbd_pkg;
    localparam int LINE_W   = 16;
    localparam int ADDR_W   = 11;
    localparam int BE_W     = 4;
    localparam int BYTE_W   = 8;
    localparam int A16_LO   = 2;
    localparam int A16_HI   = 10;
    localparam int BE_LO    = 12;
    localparam int BE_HI    = 15;
    localparam int A8_HI_W  = 3;
    localparam int A8_HI_LO = 8;
    localparam int IRQ_W    = 8;

    typedef enum logic [1:0] {
        HBD_IDLE  = 2'h0,
        HBD_WRITE = 2'h1,
        HBD_READ  = 2'h2
    } hbd_state_e;

    // pins as seen at the device boundary, strobes and select active low
    typedef struct packed {
        logic              chip_select_low;
        logic              read_strobe_low;
        logic              write_strobe_low;
        logic              addr_data_sel;
        logic              bus_mode_16;
        logic [LINE_W-1:0] shared_addr_data_lines;
    } hbd_pins_s;

    // request toward the device register file
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [BE_W-1:0]   byte_lane_enables;
        logic [LINE_W-1:0] wdata;
        logic              addr_load;
        logic              we;
        logic              re;
    } hbd_req_s;

    localparam hbd_pins_s PINS_IDLE = '{chip_select_low: 1'h1, read_strobe_low: 1'h1,
                                        write_strobe_low: 1'h1, addr_data_sel: 1'h0,
                                        bus_mode_16: 1'h0, shared_addr_data_lines: 16'h0000};
    localparam logic [LINE_W-1:0] LINES_ZERO = 16'h0000;
    localparam logic [LINE_W-1:0] OE_8BIT    = 16'h00ff;
    localparam logic [LINE_W-1:0] OE_16BIT   = 16'hffff;
    localparam logic [1:0]        A16_PAD    = 2'h0;
    localparam logic [BYTE_W-1:0] BYTE_ZERO  = 8'h00;
endpackage

// file: hdl/hbd_pin_sync.sv
// three-stage synchroniser with agreement filter, one lane per bit
`timescale 1ns/1ps
`default_nettype none
module hbd_pin_sync #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         core_clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] filt;
    } hbd_sync_s;

    hbd_sync_s    q;
    hbd_sync_s    next_q;
    logic [W-1:0] next_filt;

    // a bit moves only once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_lane
            assign next_filt[i] = (q.s2[i] == q.s3[i]) ? q.s3[i] : q.filt[i];
        end
    endgenerate

    always_comb begin
        next_q      = q;
        next_q.s1   = din;
        next_q.s2   = q.s1;
        next_q.s3   = q.s2;
        next_q.filt = next_filt;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            q <= '{s1: RST, s2: RST, s3: RST, filt: RST};
        end else begin
            q <= next_q;
        end
    end

    assign dout = q.filt;
endmodule
`default_nettype wire

// file: hdl/hbd_host_bus.sv
// multiplexed host bus decoder: strobes, address/data split, interrupt pin
// Functional notes
// - with the select low the lines carry data, all sixteen in 16-bit mode, only the low eight in 8-bit mode.
// - in 16-bit address phases address bits 10..2 come from lines 10..2 and lines 1..0 are ignored.
// - in 16-bit address phases lines 15..12 carry the four byte-lane enables and line 11 is ignored.
// - in 8-bit mode the address takes two writes, bits 7..0 first, then bits 10..8 from lines 2..0.
// - the interrupt pin is driven low whenever any interrupt status bit is set, else high.
`timescale 1ns/1ps
`default_nettype none
module hbd_host_bus
    import hbd_pkg::*;
#(
    parameter int IRQ_N = hbd_pkg::IRQ_W
) (
    input  wire logic                      core_clk,
    input  wire logic                      rstn,
    input  wire hbd_pkg::hbd_pins_s        pins,
    output logic [hbd_pkg::LINE_W-1:0]     lines_out,
    output logic [hbd_pkg::LINE_W-1:0]     lines_oe,
    output logic                           host_irq_low,
    input  wire logic [IRQ_N-1:0]          irq_status,
    input  wire logic [hbd_pkg::LINE_W-1:0] reg_rdata,
    output hbd_pkg::hbd_req_s              req
);
    import hbd_pkg::*;

    typedef struct packed {
        hbd_state_e        st;
        logic              addr_hi_next;
        logic [LINE_W-1:0] wlines;
        logic              wcmd;
        hbd_req_s          req;
        logic [LINE_W-1:0] rlines;
        logic [LINE_W-1:0] oe;
        logic              irq_low;
    } hbd_core_s;

    localparam hbd_core_s CORE_RST = '{st: HBD_IDLE, addr_hi_next: 1'h0, wlines: 16'h0000,
                                       wcmd: 1'h0, req: '0, rlines: 16'h0000,
                                       oe: 16'h0000, irq_low: 1'h1};

    hbd_pins_s p;
    hbd_core_s q;
    hbd_core_s next_q;

    hbd_pin_sync #(
        .W   ($bits(hbd_pins_s)),
        .RST (PINS_IDLE)
    ) u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .din      (pins),
        .dout     (p)
    );

    always_comb begin
        next_q = q;
        next_q.req.we = 1'h0;
        next_q.req.re = 1'h0;
        next_q.req.addr_load = 1'h0;
        next_q.irq_low = ~(|irq_status);
        case (q.st)
            HBD_IDLE: begin
                next_q.oe = LINES_ZERO;
                if (!p.chip_select_low && !p.write_strobe_low) begin
                    next_q.st = HBD_WRITE;
                    next_q.wlines = p.shared_addr_data_lines;
                    next_q.wcmd = p.addr_data_sel;
                end else if (!p.chip_select_low && !p.read_strobe_low) begin
                    next_q.st = HBD_READ;
                    next_q.req.re = 1'h1;
                end
            end
            HBD_WRITE: begin
                if (p.chip_select_low) begin
                    next_q.st = HBD_IDLE;
                end else if (!p.write_strobe_low) begin
                    next_q.wlines = p.shared_addr_data_lines;
                    next_q.wcmd = p.addr_data_sel;
                end else begin
                    // strobe rose: commit what was on the lines just before
                    next_q.st = HBD_IDLE;
                    if (!q.wcmd) begin
                        next_q.req.we = 1'h1;
                        next_q.req.wdata = p.bus_mode_16 ? q.wlines
                                                         : {BYTE_ZERO, q.wlines[BYTE_W-1:0]};
                    end else if (p.bus_mode_16) begin
                        next_q.req.addr = {q.wlines[A16_HI:A16_LO], A16_PAD};
                        next_q.req.byte_lane_enables = q.wlines[BE_HI:BE_LO];
                        next_q.req.addr_load = 1'h1;
                        next_q.addr_hi_next = 1'h0;
                    end else if (!q.addr_hi_next) begin
                        next_q.req.addr[BYTE_W-1:0] = q.wlines[BYTE_W-1:0];
                        next_q.addr_hi_next = 1'h1;
                    end else begin
                        next_q.req.addr[ADDR_W-1:A8_HI_LO] = q.wlines[A8_HI_W-1:0];
                        next_q.req.addr_load = 1'h1;
                        next_q.addr_hi_next = 1'h0;
                    end
                end
            end
            HBD_READ: begin
                if (p.chip_select_low || p.read_strobe_low) begin
                    next_q.st = HBD_IDLE;
                    next_q.oe = LINES_ZERO;
                end else begin
                    next_q.rlines = p.bus_mode_16 ? reg_rdata : {BYTE_ZERO, reg_rdata[BYTE_W-1:0]};
                    next_q.oe = p.bus_mode_16 ? OE_16BIT : OE_8BIT;
                end
            end
            default: begin
                next_q = CORE_RST;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            q <= CORE_RST;
        end else begin
            q <= next_q;
        end
    end

    assign lines_out    = q.rlines;
    assign lines_oe     = q.oe;
    assign host_irq_low = q.irq_low;
    assign req          = q.req;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    irq_set_low_a: assert property ((|irq_status) |=> !host_irq_low)
        else $error("interrupt pin not low with status set");
    irq_clear_high_a: assert property (!(|irq_status) |=> host_irq_low)
        else $error("interrupt pin low with no status set");
    data_byte_a: assert property (req.we && !p.bus_mode_16 |-> req.wdata[15:8] == 8'h00)
        else $error("upper data byte set in 8-bit mode");
    addr16_low_a: assert property (req.addr_load && $past(p.bus_mode_16)
        |-> req.addr[1:0] == 2'h0 && req.addr[10:2] == $past(q.wlines[10:2]))
        else $error("16-bit address not taken from lines 10..2");
    lane_enable_a: assert property (req.addr_load && $past(p.bus_mode_16)
        |-> req.byte_lane_enables == $past(q.wlines[15:12]))
        else $error("byte enables not from lines 15..12");
    addr8_pair_a: assert property (req.addr_load && !$past(p.bus_mode_16) |-> $past(q.addr_hi_next))
        else $error("8-bit address loaded after one write");
    read_drive_a: assert property ($rose(q.st == HBD_READ) |=> lines_oe[7:0] == 8'hff)
        else $error("read not driving lines");
    cs_ignore_a: assert property (p.chip_select_low |=> !req.we && !req.re && !req.addr_load)
        else $error("access taken with chip select high");
    write_commit_a: assert property ((req.we || req.addr_load) |-> $past(q.st) == HBD_WRITE)
        else $error("write committed outside a write strobe");

    // read path: lines follow the register data while the strobe stays low
    read_follow_a: assert property (q.st == HBD_READ && !p.chip_select_low && !p.read_strobe_low && p.bus_mode_16
        |=> lines_oe == OE_16BIT && lines_out == $past(reg_rdata))
        else $error("16-bit read not presenting register data");
    read_byte_a: assert property (q.st == HBD_READ && !p.chip_select_low && !p.read_strobe_low && !p.bus_mode_16
        |=> lines_oe == OE_8BIT && lines_out == {BYTE_ZERO, $past(reg_rdata[BYTE_W-1:0])})
        else $error("8-bit read not presenting low data byte");
    read_release_a: assert property (q.st == HBD_READ && (p.chip_select_low || p.read_strobe_low)
        |=> lines_oe == LINES_ZERO)
        else $error("lines still driven after read strobe rose");
    idle_quiet_a: assert property (q.st == HBD_IDLE |=> lines_oe == LINES_ZERO)
        else $error("lines driven while idle");
    read_once_a: assert property (req.re |=> !req.re)
        else $error("read start pulse longer than one cycle");

    // write path: committed values match the lines held before the strobe rose
    write_no_read_a: assert property (q.st == HBD_WRITE |=> !req.re)
        else $error("read started during a write");
    data_word_a: assert property (req.we && $past(p.bus_mode_16)
        |-> req.wdata == $past(q.wlines))
        else $error("16-bit data word not taken from all lines");
    data_low_a: assert property (req.we
        |-> req.wdata[BYTE_W-1:0] == $past(q.wlines[BYTE_W-1:0]))
        else $error("low data byte not taken from lines 7..0");
    addr8_low_a: assert property ($rose(q.addr_hi_next)
        |-> req.addr[BYTE_W-1:0] == $past(q.wlines[BYTE_W-1:0]))
        else $error("first 8-bit address write not taken from lines 7..0");
    addr8_high_a: assert property (req.addr_load && !$past(p.bus_mode_16)
        |-> req.addr[10:8] == $past(q.wlines[2:0]) && $stable(req.addr[BYTE_W-1:0]))
        else $error("second 8-bit address write not taken from lines 2..0");
    pulse_once_a: assert property ((req.we || req.addr_load) |=> !req.we && !req.addr_load)
        else $error("write commit pulse longer than one cycle");

    // held request fields change only when their strobe pulses, and the address also on the first 8-bit address write
    wdata_hold_a: assert property (!req.we |-> $stable(req.wdata))
        else $error("write data changed without a data write");
    be_hold_a: assert property (!req.addr_load |-> $stable(req.byte_lane_enables))
        else $error("byte enables changed without an address load");
    addr_hold_a: assert property (!req.addr_load && !$rose(q.addr_hi_next)
        |-> $stable(req.addr))
        else $error("address changed without an address write");

    c_addr16: cover property (req.addr_load && p.bus_mode_16);
    c_addr8: cover property (req.addr_load && !p.bus_mode_16);
    c_data_write: cover property (req.we);
    c_read: cover property (req.re ##[1:20] lines_oe != 16'h0000);
    c_addr8_first: cover property ($rose(q.addr_hi_next));
endmodule
`default_nettype wire

// file: testbench/hbd_host_model.sv
// host processor model driving the multiplexed bus pins
`timescale 1ns/1ps
`default_nettype none
module hbd_host_model (
    input  wire logic                      core_clk,
    input  wire logic [hbd_pkg::LINE_W-1:0] lines_out,
    input  wire logic [hbd_pkg::LINE_W-1:0] lines_oe,
    input  wire logic                      mode_16,
    output var  hbd_pkg::hbd_pins_s        pins
);
    import hbd_pkg::*;
    logic [LINE_W-1:0] drv    = 16'h0000;
    logic              drv_en = 1'h0;
    logic              cs     = 1'h1;
    logic              rd     = 1'h1;
    logic              wr     = 1'h1;
    logic              sel    = 1'h0;
    // released lines show the inverse of drv, the value given to the latest access
    assign pins = '{chip_select_low: cs, read_strobe_low: rd, write_strobe_low: wr, addr_data_sel: sel,
                    bus_mode_16: mode_16,
                    shared_addr_data_lines: (lines_oe & lines_out) | (~lines_oe & (drv_en ? drv : ~drv))};
    // one bus access, 2 clocks setup, strobe held 8 clocks, 8 more to the select rise, 6 idle after, lines held past the strobe rise
    task automatic access(input logic sel_v, input logic is_rd, input logic cs_v, input logic [LINE_W-1:0] d,
                          output logic [LINE_W-1:0] oe_s, output logic [LINE_W-1:0] out_s);
        @(posedge core_clk);
        cs <= cs_v;
        sel <= sel_v;
        drv <= d;
        drv_en <= !is_rd;
        repeat (2) @(posedge core_clk);
        if (is_rd) begin
            rd <= 1'h0;
        end else begin
            wr <= 1'h0;
        end
        repeat (8) @(posedge core_clk);
        oe_s = lines_oe;
        out_s = lines_out;
        rd <= 1'h1;
        wr <= 1'h1;
        repeat (8) @(posedge core_clk);
        cs <= 1'h1;
        drv_en <= 1'h0;
        repeat (6) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// file: testbench/muxed_host_bus_decode_tb_top.sv
// self-checking bench for the multiplexed host bus decoder
`timescale 1ns/1ps
`default_nettype none
module muxed_host_bus_decode_tb_top;
    import hbd_pkg::*;
    logic              core_clk   = 1'h0;
    logic              rstn       = 1'h0;
    logic              mode_16    = 1'h1;
    logic [IRQ_W-1:0]  irq_status = 8'h00;
    logic [LINE_W-1:0] reg_rdata  = 16'h0000;
    hbd_pins_s         pins;
    logic [LINE_W-1:0] lines_out;
    logic [LINE_W-1:0] lines_oe;
    logic              host_irq_low;
    hbd_req_s          req;
    logic [LINE_W-1:0] oe_s, out_s, a, b, d;
    int                errors, comparisons, cycles, n_ld, n_we, n_re;
    always #20 core_clk = ~core_clk;
    hbd_host_bus dut_u (.core_clk(core_clk), .rstn(rstn), .pins(pins), .lines_out(lines_out),
        .lines_oe(lines_oe), .host_irq_low(host_irq_low), .irq_status(irq_status),
        .reg_rdata(reg_rdata), .req(req));
    hbd_host_model host_u (.core_clk(core_clk), .lines_out(lines_out), .lines_oe(lines_oe),
        .mode_16(mode_16), .pins(pins));
    task automatic tally_and_finish();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [LINE_W-1:0] got, input logic [LINE_W-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic do_reset(input logic m);
        @(posedge core_clk);
        rstn <= 1'h0;
        mode_16 <= m;
        irq_status <= 8'h00;
        repeat (12) @(posedge core_clk);
        rstn <= 1'h1;
        repeat (2) @(posedge core_clk);
        chk(lines_oe, LINES_ZERO);
        chk({15'h0000, host_irq_low}, 16'h0001);
        chk(req.wdata, LINES_ZERO);
        n_ld = 0;
        n_we = 0;
        n_re = 0;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (req.addr_load === 1'h1) n_ld++;
        if (req.we === 1'h1) n_we++;
        if (req.re === 1'h1) n_re++;
        if (cycles == 5000) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        void'($urandom(62018));
        do_reset(1'h1);
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            irq_status <= 8'(i % 2 == 0 ? 0 : $urandom_range(255, 1));
            repeat (3) @(posedge core_clk);
            chk({15'h0000, host_irq_low}, {15'h0000, irq_status == 8'h00});
        end
        for (int i = 0; i < 4; i++) begin
            a = 16'($urandom);
            d = 16'($urandom);
            host_u.access(1'h1, 1'h0, 1'h0, a, oe_s, out_s);
            chk({5'h00, req.addr}, {5'h00, a[10:2], A16_PAD});
            chk({12'h000, req.byte_lane_enables}, {12'h000, a[15:12]});
            host_u.access(1'h0, 1'h0, 1'h0, d, oe_s, out_s);
            chk(req.wdata, d);
            host_u.access(1'h1, 1'h0, 1'h1, ~a, oe_s, out_s);
            chk({5'h00, req.addr}, {5'h00, a[10:2], A16_PAD});
            reg_rdata <= d ^ 16'h5a5a;
            host_u.access(1'h0, 1'h1, 1'h0, a, oe_s, out_s);
            chk(oe_s, OE_16BIT);
            chk(out_s, d ^ 16'h5a5a);
            chk(lines_oe, LINES_ZERO);
        end
        chk(16'(n_ld), 16'h0004);
        chk(16'(n_we), 16'h0004);
        chk(16'(n_re), 16'h0004);
        do_reset(1'h0);
        for (int i = 0; i < 3; i++) begin
            a = 16'($urandom);
            b = 16'($urandom);
            d = 16'($urandom);
            host_u.access(1'h1, 1'h0, 1'h0, a, oe_s, out_s);
            host_u.access(1'h1, 1'h0, 1'h0, b, oe_s, out_s);
            chk({5'h00, req.addr}, {5'h00, b[2:0], a[7:0]});
            host_u.access(1'h0, 1'h0, 1'h0, d, oe_s, out_s);
            chk(req.wdata, {BYTE_ZERO, d[7:0]});
            reg_rdata <= d;
            host_u.access(1'h0, 1'h1, 1'h0, a, oe_s, out_s);
            chk(oe_s, OE_8BIT);
            chk(out_s & OE_8BIT, d & OE_8BIT);
        end
        chk(16'(n_ld), 16'h0003);
        chk(16'(n_we), 16'h0003);
        chk(16'(n_re), 16'h0003);
        tally_and_finish();
    end
endmodule
`default_nettype wire
